//--- rtl/framer_pkg.sv
// Constants shared by the LVDS sample strobe framer
// Notes on behaviour
// R01: Four 12-bit LVDS buses: 48 data pairs, four DDR clocks, four strobes.
// R02: Strobe comes from the internal generator, the timestamp input or SYSREF.
// R03: With scrambling on, the receiver undoes it to recover the samples.
// R04: A SYSREF event resets the clock divider and the strobe counters.
// R05: Strobe is high only in the final unit interval of each frame.
// R06: Frame length register sets unit intervals per frame; 0x08 gives UI 0..7.
// R07: SYSREF starts a frame; a periodic SYSREF spans whole frames.
// R08: Strobe leaves with the same timing as data, beside its bus clock.
// R09: Sync source is the control bit, the sync pin or the timestamp input.
// R10: Dedicated strobe pair runs without sync; data keeps all 12 bits.
// R11: Dedicated strobe may run continuously or be switched on and off.
// R12: In two-bus mode buses C and D clocks and strobes may be off.
// R13: Pattern 0x2 with sync on: bit 0 carries the strobe, bits 11..1 sample.
// R14: Pattern 0x2 with sync off: the full 12-bit sample is sent.
// R15: After reset the sync pin decides when the strobe is sent.
// R16: Pattern 0x3 with sync on: 0x000 each UI, 0xFFF in the last one.
// R17: Pattern 0x3 with sync off: full samples; enabled strobe pairs keep marking.
// R18: Scrambled bit k is sample bit k xor bit 1 xor bit 0; bit 0 here carries bit 1 xor bit 0.
// R19: Each bus strobe and each bus data clock has its own enable bit.
// R20: Per-bus UI counter cleared by SYSREF wraps at length minus one.
package framer_pkg;
  localparam int unsigned NUM_BUS  = 4;
  localparam int unsigned SAMPLE_W = 12;
  localparam int unsigned CNT_W    = 8;

  localparam logic [31:0] OFS_CTRL   = 32'h0000_0000;
  localparam logic [31:0] OFS_FRAME  = 32'h0000_0004;
  localparam logic [31:0] OFS_PATSEL = 32'h0000_0008;
  localparam logic [31:0] OFS_CLKSTR = 32'h0000_000c;
  localparam logic [31:0] OFS_STATUS = 32'h0000_0010;

  localparam int unsigned CTRL_W       = 7;
  localparam int unsigned CTRL_SCR     = 0;
  localparam int unsigned CTRL_SEL_LO  = 1;
  localparam int unsigned CTRL_SRC_LO  = 3;
  localparam int unsigned CTRL_SPI     = 5;
  localparam int unsigned CTRL_QUAD    = 6;
  localparam int unsigned CLKSTR_DCLK  = 4;
  localparam int unsigned STAT_SYNC    = 8;

  localparam logic [6:0] CTRL_RST   = 7'h42;
  localparam logic [7:0] FRAME_RST  = 8'h08;
  localparam logic [1:0] PAT_RST    = 2'h0;
  localparam logic [7:0] CLKSTR_RST = 8'hff;

  localparam logic [1:0] SEL_SPI = 2'h0;
  localparam logic [1:0] SEL_PIN = 2'h1;
  localparam logic [1:0] SEL_TS  = 2'h2;

  localparam logic [1:0] SRC_INT    = 2'h0;
  localparam logic [1:0] SRC_TS     = 2'h1;
  localparam logic [1:0] SRC_SYSREF = 2'h2;

  localparam logic [1:0] PAT_LSB = 2'h2;
  localparam logic [1:0] PAT_ALL = 2'h3;

  localparam logic [11:0] WORD_ZERO = 12'h000;
  localparam logic [11:0] WORD_ONES = 12'hfff;
endpackage

//--- rtl/pin_sync.sv
// Two-stage synchroniser for the asynchronous input pins
`timescale 1ns/1ns
`default_nettype none
module pin_sync (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic [2:0] async_in,
  output logic      [2:0] sync_out
);
  typedef struct packed {
    logic [2:0] s1;
    logic [2:0] s2;
  } sync_t;

  sync_t s_r;
  sync_t s_nxt;

  always_comb begin
    s_nxt    = s_r;
    s_nxt.s1 = async_in;
    s_nxt.s2 = s_r.s1;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign sync_out = s_r.s2;
endmodule
`default_nettype wire

//--- rtl/lane_former.sv
// Forms one bus word: sync pattern, LSB strobe and scrambler
`timescale 1ns/1ns
`default_nettype none
module lane_former (
  input  wire logic [11:0] sample,
  input  wire logic        strobe,
  input  wire logic [1:0]  pattern,
  input  wire logic        sync_act,
  input  wire logic        scramble,
  output logic      [11:0] word
);
  logic [11:0] d;
  logic        key;

  always_comb begin
    d = sample;                                      // R14 R17
    if (sync_act && pattern == framer_pkg::PAT_LSB) begin
      d[0] = strobe;                                 // R13
    end else if (sync_act && pattern == framer_pkg::PAT_ALL) begin
      d = strobe ? framer_pkg::WORD_ONES : framer_pkg::WORD_ZERO; // R16
    end
    key  = d[1] ^ d[0];
    word = d;
    if (scramble) begin
      word[11:2] = d[11:2] ^ {10{key}};              // R18
      word[1]    = d[0];
      word[0]    = key;
    end
  end
endmodule
`default_nettype wire

//--- rtl/lvds_sample_strobe_framer.sv
// Strobe framer for four LVDS sample buses with AHB-Lite registers
//
// Chosen here: the address map and the AHB-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
module lvds_sample_strobe_framer (
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic             hsel,
  input  wire logic [31:0]      haddr,
  input  wire logic [1:0]       htrans,
  input  wire logic             hwrite,
  input  wire logic [2:0]       hsize,
  input  wire logic [31:0]      hwdata,
  input  wire logic             hready,
  output logic                  hreadyout,
  output logic                  hresp,
  output logic      [31:0]      hrdata,
  input  wire logic [3:0][11:0] sample_in,
  input  wire logic             sysref_in,
  input  wire logic             timestamp_input,
  input  wire logic             single_ended_sync_pin,
  output logic      [3:0][11:0] bus_data_pairs,
  output logic      [3:0]       bus_strobe_pair,
  output logic      [3:0]       bus_data_clock
);
  typedef struct packed {
    logic             ready;
    logic             resp;
    logic [31:0]      rdata;
    logic             wr_pend;
    logic [31:0]      wr_addr;
    logic [6:0]       ctrl;
    logic [7:0]       frame_len;
    logic [1:0]       pat;
    logic [7:0]       clkstr;
    logic             sysref_prev;
    logic             dclk;
    logic [3:0][7:0]  ui_cnt;
    logic [3:0][11:0] data;
    logic [3:0]       stb;
    logic [3:0]       clk;
  } state_t;

  state_t s_r;
  state_t s_nxt;

  logic [2:0]       pins_s;
  logic             sysref_s;
  logic             ts_s;
  logic             pin_s;
  logic             sysref_edge;
  logic             acc;
  logic             sync_act;
  logic [1:0]       sync_sel;
  logic [1:0]       src;
  logic             quad;
  logic [3:0]       stb_en;
  logic [3:0]       clk_en;
  logic [7:0]       last;
  logic [3:0]       strb;
  logic [3:0][11:0] word;
  logic [3:0][7:0]  cnt_nxt;
  logic [3:0][11:0] data_nxt;
  logic [3:0]       stb_nxt;
  logic [3:0]       clk_nxt;
  logic [9:0]       scr_ref;

  pin_sync u_pins (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .async_in ({single_ended_sync_pin, timestamp_input, sysref_in}),
    .sync_out (pins_s)
  );

  assign sysref_s = pins_s[0];
  assign ts_s     = pins_s[1];
  assign pin_s    = pins_s[2];

  // Register fields
  assign sync_sel = s_r.ctrl[framer_pkg::CTRL_SEL_LO +: 2];
  assign src      = s_r.ctrl[framer_pkg::CTRL_SRC_LO +: 2];
  assign quad     = s_r.ctrl[framer_pkg::CTRL_QUAD];
  assign stb_en   = s_r.clkstr[3:0];
  assign clk_en   = s_r.clkstr[framer_pkg::CLKSTR_DCLK +: 4];
  assign last     = s_r.frame_len - 8'h01;
  assign acc      = hsel && htrans[1] && hready;

  assign sysref_edge = sysref_s && !s_r.sysref_prev;  // R04 R07

  // Sync source select, pin after reset
  always_comb begin
    case (sync_sel)
      framer_pkg::SEL_SPI: sync_act = s_r.ctrl[framer_pkg::CTRL_SPI]; // R09
      framer_pkg::SEL_PIN: sync_act = pin_s;                          // R09 R15
      framer_pkg::SEL_TS:  sync_act = ts_s;                           // R09
      default:             sync_act = pin_s;
    endcase
  end

  // Per-bus counter, strobe and word
  for (genvar g = 0; g < 4; g++) begin : g_bus
    logic on;
    logic pick;
    assign on = (g < 2) || quad;                                       // R12
    always_comb begin
      case (src)
        framer_pkg::SRC_INT:    pick = (s_r.ui_cnt[g] >= last);       // R05 R20
        framer_pkg::SRC_TS:     pick = ts_s;                          // R02
        framer_pkg::SRC_SYSREF: pick = sysref_s;                      // R02
        default:                pick = (s_r.ui_cnt[g] >= last);
      endcase
    end
    assign strb[g] = pick;
    assign cnt_nxt[g] = (sysref_edge || s_r.ui_cnt[g] >= last) ? 8'h00 // R04 R06 R20
                        : s_r.ui_cnt[g] + 8'h01;
    lane_former u_lane (
      .sample   (sample_in[g]),
      .strobe   (strb[g]),
      .pattern  (s_r.pat),
      .sync_act (sync_act),
      .scramble (s_r.ctrl[framer_pkg::CTRL_SCR]),
      .word     (word[g])
    );
    assign data_nxt[g] = on ? word[g] : framer_pkg::WORD_ZERO;         // R01
    assign stb_nxt[g]  = on && stb_en[g] && strb[g];                   // R10 R11 R17 R19
    assign clk_nxt[g]  = on && clk_en[g] && s_r.dclk;                  // R19
  end

  always_comb begin
    s_nxt             = s_r;
    s_nxt.ready       = 1'b1;
    s_nxt.resp        = 1'b0;
    s_nxt.wr_pend     = acc && hwrite;
    s_nxt.wr_addr     = haddr;
    s_nxt.sysref_prev = sysref_s;
    s_nxt.dclk        = sysref_edge ? 1'b0 : !s_r.dclk;                // R04
    s_nxt.ui_cnt      = cnt_nxt;
    s_nxt.data        = data_nxt;                                       // R08
    s_nxt.stb         = stb_nxt;                                        // R08
    s_nxt.clk         = clk_nxt;
    if (s_r.wr_pend) begin
      case (s_r.wr_addr)
        framer_pkg::OFS_CTRL:   s_nxt.ctrl      = hwdata[6:0];
        framer_pkg::OFS_FRAME:  s_nxt.frame_len = hwdata[7:0];          // R06
        framer_pkg::OFS_PATSEL: s_nxt.pat       = hwdata[1:0];
        framer_pkg::OFS_CLKSTR: s_nxt.clkstr    = hwdata[7:0];          // R19
        default: begin
        end
      endcase
    end
    s_nxt.rdata = 32'h0000_0000;
    if (acc && !hwrite) begin
      case (haddr)
        framer_pkg::OFS_CTRL:   s_nxt.rdata = {25'h0, s_r.ctrl};
        framer_pkg::OFS_FRAME:  s_nxt.rdata = {24'h0, s_r.frame_len};
        framer_pkg::OFS_PATSEL: s_nxt.rdata = {30'h0, s_r.pat};
        framer_pkg::OFS_CLKSTR: s_nxt.rdata = {24'h0, s_r.clkstr};
        framer_pkg::OFS_STATUS: s_nxt.rdata = {23'h0, sync_act, s_r.ui_cnt[0]};
        default:                s_nxt.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r <= '{ready:     1'b1,
               ctrl:      framer_pkg::CTRL_RST,
               frame_len: framer_pkg::FRAME_RST,
               pat:       framer_pkg::PAT_RST,
               clkstr:    framer_pkg::CLKSTR_RST,
               default:   '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign hreadyout       = s_r.ready;
  assign hresp           = s_r.resp;
  assign hrdata          = s_r.rdata;
  assign bus_data_pairs  = s_r.data;
  assign bus_strobe_pair = s_r.stb;
  assign bus_data_clock  = s_r.clk;

  // Checks
  assign scr_ref = sample_in[0][11:2] ^ {10{sample_in[0][1] ^ sample_in[0][0]}};

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence s_wrap;
    !sysref_edge && s_r.ui_cnt[0] >= last;
  endsequence

  sequence s_count_up;
    !sysref_edge && s_r.ui_cnt[0] < last;
  endsequence

  sequence s_int_strobe;
    src == framer_pkg::SRC_INT && stb_en[0];
  endsequence

  sysref_clear_a: assert property ( // R04
    sysref_edge |=> (s_r.ui_cnt == '0) && !s_r.dclk ##1 s_r.dclk)
    else $error("sysref did not reset counters and divider");

  wrap_count_a: assert property ( // R20
    s_wrap |=> s_r.ui_cnt[0] == 8'h00)
    else $error("ui counter did not wrap");

  count_up_a: assert property ( // R06
    s_count_up |=> s_r.ui_cnt[0] == $past(s_r.ui_cnt[0]) + 8'h01)
    else $error("ui counter did not advance");

  strobe_last_a: assert property ( // R05
    s_int_strobe |=> bus_strobe_pair[0] == ($past(s_r.ui_cnt[0]) >= $past(last)))
    else $error("strobe not in last ui only");

  strobe_mirror_a: assert property ( // R02
    (src == framer_pkg::SRC_SYSREF && stb_en[0]) |=> bus_strobe_pair[0] == $past(sysref_s))
    else $error("strobe did not mirror sysref");

  lsb_strobe_a: assert property ( // R13
    (s_r.pat == framer_pkg::PAT_LSB && sync_act && !s_r.ctrl[framer_pkg::CTRL_SCR])
    |=> bus_data_pairs[0] == {$past(sample_in[0][11:1]), $past(strb[0])})
    else $error("lsb not replaced by strobe");

  lsb_full_a: assert property ( // R14
    (s_r.pat == framer_pkg::PAT_LSB && !sync_act && !s_r.ctrl[framer_pkg::CTRL_SCR])
    |=> bus_data_pairs[0] == $past(sample_in[0]))
    else $error("full sample not sent");

  all_pairs_a: assert property ( // R16
    (s_r.pat == framer_pkg::PAT_ALL && sync_act && !s_r.ctrl[framer_pkg::CTRL_SCR])
    |=> bus_data_pairs[1] == {12{$past(strb[1])}})
    else $error("all-pairs pattern wrong");

  scramble_a: assert property ( // R18
    (s_r.ctrl[framer_pkg::CTRL_SCR] && !sync_act)
    |=> bus_data_pairs[0][11:2] == $past(scr_ref))
    else $error("scrambled bits wrong");

  strobe_off_a: assert property ( // R19
    !stb_en[2] |=> !bus_strobe_pair[2])
    else $error("disabled strobe active");

  clock_off_a: assert property ( // R19
    !clk_en[2] |=> !bus_data_clock[2])
    else $error("disabled data clock active");

  narrow_off_a: assert property ( // R12
    !quad |=> bus_data_pairs[3] == framer_pkg::WORD_ZERO && !bus_data_clock[3])
    else $error("bus d active in two-bus mode");

  sync_pin_a: assert property ( // R09
    sync_sel == framer_pkg::SEL_PIN |-> sync_act == $past(single_ended_sync_pin, 2))
    else $error("sync not taken from pin");

  // Pattern insertion with sync active and a strobe pair enabled
  sequence s_lsb_sync;
    s_r.pat == framer_pkg::PAT_LSB && sync_act
    && !s_r.ctrl[framer_pkg::CTRL_SCR] && stb_en[0];
  endsequence

  sequence s_all_sync;
    s_r.pat == framer_pkg::PAT_ALL && sync_act
    && !s_r.ctrl[framer_pkg::CTRL_SCR] && stb_en[1];
  endsequence

  strobe_pair_a: assert property ( // R08
    s_lsb_sync |=> bus_strobe_pair[0] == bus_data_pairs[0][0])
    else $error("strobe pair and lsb differ");

  all_marker_a: assert property ( // R16
    s_all_sync |=> bus_data_pairs[1] == {12{bus_strobe_pair[1]}})
    else $error("all-pairs marker not with strobe");

  ts_mirror_a: assert property ( // R02
    (src == framer_pkg::SRC_TS && stb_en[0]) |=> bus_strobe_pair[0] == $past(ts_s))
    else $error("strobe did not mirror timestamp");

  narrow_stb_a: assert property ( // R12
    !quad |=> !bus_strobe_pair[2] && !bus_data_clock[2])
    else $error("bus c clock or strobe active in two-bus mode");

  ded_strobe_a: assert property ( // R10
    (src == framer_pkg::SRC_INT && stb_en[2] && quad && !sync_act)
    |=> bus_strobe_pair[2] == ($past(s_r.ui_cnt[2]) >= $past(last)))
    else $error("dedicated strobe needs sync");

  all_idle_a: assert property ( // R17
    (s_r.pat == framer_pkg::PAT_ALL && !sync_act && !s_r.ctrl[framer_pkg::CTRL_SCR] && quad)
    |=> bus_data_pairs[2] == $past(sample_in[2]))
    else $error("full sample not sent without sync");

  scramble_lsb_a: assert property ( // R18
    (s_r.ctrl[framer_pkg::CTRL_SCR] && !sync_act)
    |=> bus_data_pairs[0][1:0] == {$past(sample_in[0][0]),
                                   $past(sample_in[0][1] ^ sample_in[0][0])})
    else $error("scrambled low bits wrong");

  count_bound_a: assert property ( // R20
    $stable(last) |-> s_r.ui_cnt[0] <= last)
    else $error("ui counter past frame end");
endmodule
`default_nettype wire

//--- dv/lvds_rx_model.sv
// Receiver model that undoes the bus scrambler
`timescale 1ns/1ns
`default_nettype none
module lvds_rx_model (
  input  wire logic [11:0] word_in,
  input  wire logic        descramble,
  output logic      [11:0] recovered
);
  always_comb begin
    recovered = word_in;
    if (descramble) begin
      for (int k = 2; k < 12; k++) recovered[k] = word_in[k] ^ word_in[0];
      recovered[1] = word_in[1] ^ word_in[0];
      recovered[0] = word_in[1];
    end
  end
endmodule
`default_nettype wire

//--- dv/lvds_sample_strobe_framer_tb.sv
// Testbench for the LVDS sample strobe framer
`timescale 1ns/1ns
`default_nettype none
module lvds_sample_strobe_framer_tb;
  logic             hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0]      haddr, hwdata, hrdata;
  logic [1:0]       htrans, pat;
  logic [2:0]       hsize;
  logic [3:0][11:0] sample_in, bus_data_pairs;
  logic [3:0]       bus_strobe_pair, bus_data_clock, prev_clk;
  logic             sysref_in, timestamp_input, single_ended_sync_pin, chk, seen;
  logic [6:0]       ctrl;
  logic [7:0]       flen, ena;
  logic [11:0]      recovered;
  logic [3:0][11:0] q[$];
  int               error_cnt, check_count, per_cnt;
  assign hready = hreadyout;
  lvds_sample_strobe_framer dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .sample_in(sample_in),
    .sysref_in(sysref_in), .timestamp_input(timestamp_input),
    .single_ended_sync_pin(single_ended_sync_pin), .bus_data_pairs(bus_data_pairs),
    .bus_strobe_pair(bus_strobe_pair), .bus_data_clock(bus_data_clock));
  lvds_rx_model rx (.word_in(bus_data_pairs[0]), .descramble(ctrl[0]), .recovered(recovered));
  always #20 hclk = ~hclk;
  task automatic cmp(input string what, input logic [31:0] e, a);
    check_count++;
    if (e !== a) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", what, e, a);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [31:0] a, d, output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
    cmp("response", 32'h0, 32'(hresp));
  endtask
  task automatic rdchk(input logic [31:0] a, e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    cmp("register", e, r);
  endtask
  // Write, then realign frames with SYSREF before checking resumes
  task automatic wr(input logic [31:0] a, d);
    logic [31:0] r;
    chk = 1'b0;
    bus(1'b1, a, d, r);
    sysref_in <= 1'b1;
    repeat (3) @(posedge hclk);
    sysref_in <= 1'b0;
    repeat (8) @(posedge hclk);
    chk = 1'b1;
  endtask
  function automatic logic [11:0] exp_word(input logic [11:0] d, input logic stb, s);
    logic [11:0] w;
    w = d;
    if (s && pat == framer_pkg::PAT_LSB) w[0] = stb;
    if (s && pat == framer_pkg::PAT_ALL) w = stb ? framer_pkg::WORD_ONES : framer_pkg::WORD_ZERO;
    if (ctrl[0]) begin
      w = w ^ {{11{w[1] ^ w[0]}}, w[1]};
    end
    return w;
  endfunction
  initial begin : drv
    logic [3:0][11:0] nx;
    void'($urandom(78));
    forever begin
      @(posedge hclk);
      for (int b = 0; b < 4; b++) nx[b] = 12'($urandom());
      sample_in <= nx;
      q.push_back(nx);
    end
  end
  always @(negedge hclk) begin : mon
    logic [3:0][11:0] n;
    logic s;
    logic lv;
    logic [11:0] ew;
    s = ctrl[2:1] == 2'h0 ? ctrl[5] : ctrl[2:1] == 2'h2 ? timestamp_input : single_ended_sync_pin;
    per_cnt++;
    if (q.size() > 1) begin
      n = q.pop_front();
      for (int b = 0; b < 4 && chk; b++) begin
        lv = ctrl[6] || b < 2;
        ew = lv ? exp_word(n[b], bus_strobe_pair[0], s) : framer_pkg::WORD_ZERO;
        cmp("data", 32'(ew), 32'(bus_data_pairs[b]));
        cmp("strobe", ena[b] & lv & bus_strobe_pair[0], bus_strobe_pair[b]);
        cmp("clock", ena[4+b] & lv & ~prev_clk[b], bus_data_clock[b]);
      end
      if (chk && ctrl[0] && !(s && pat == 2'h3)) cmp("descrambled", n[0][11:1], recovered[11:1]);
    end
    if (bus_strobe_pair[0] === 1'b1) begin
      if (chk && seen) cmp("frame period", flen == 8'h0 ? 256 : flen, per_cnt);
      seen = chk;
      per_cnt = 0;
    end
    if (!chk) seen = 1'b0;
    prev_clk = bus_data_clock;
  end
  initial begin
    #(40 * 20000);
    error_cnt++;
    tally_and_finish();
  end
  initial begin : main
    int d[2];
    hclk = 0; hresetn = 0; hsel = 0; haddr = 0; htrans = 0; hwrite = 0; hsize = 3'h2;
    hwdata = 0; sample_in = '0; sysref_in = 0; timestamp_input = 0; chk = 0; seen = 0;
    single_ended_sync_pin = 0; ctrl = 7'h42; pat = 0; flen = 8'h08; ena = 8'hff;
    prev_clk = 0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdchk(framer_pkg::OFS_CTRL, 32'h42);
    rdchk(framer_pkg::OFS_FRAME, 32'h08);
    rdchk(framer_pkg::OFS_PATSEL, 32'h0);
    rdchk(framer_pkg::OFS_CLKSTR, 32'hff);
    rdchk(32'h0000_0020, 32'h0);
    flen = 8'h05;
    wr(framer_pkg::OFS_FRAME, 32'h5);
    rdchk(framer_pkg::OFS_FRAME, 32'h5);
    repeat (20) @(posedge hclk);
    for (int i = 0; i < 4; i++) begin
      pat = i < 2 ? 2'h2 : 2'h3;
      single_ended_sync_pin <= i[0];
      wr(framer_pkg::OFS_PATSEL, 32'(pat));
      repeat (20) @(posedge hclk);
    end
    for (int s = 0; s < 3; s++) begin
      for (int on = 0; on < 2; on++) begin
        ctrl = 7'h40 | 7'(s << 1) | ((s == 0) == (on == 1) ? 7'h20 : 7'h0);
        single_ended_sync_pin <= (s == 1) == (on == 1);
        timestamp_input <= (s == 2) == (on == 1);
        wr(framer_pkg::OFS_CTRL, 32'(ctrl));
        repeat (12) @(posedge hclk);
      end
    end
    // Two-bus mode with the strobe mirrored from SYSREF, then from the timestamp input
    for (int k = 0; k < 2; k++) begin
      ctrl = k == 0 ? 7'h12 : 7'h0a;
      timestamp_input <= 1'b0;
      wr(framer_pkg::OFS_CTRL, 32'(ctrl));
      repeat (12) @(posedge hclk);
      chk = 1'b0;
      if (k == 0) sysref_in <= 1'b1;
      else timestamp_input <= 1'b1;
      @(posedge hclk);
      sysref_in <= 1'b0;
      timestamp_input <= 1'b0;
      repeat (2) @(negedge hclk);
      cmp("mirrored strobe early", 32'h0, 32'(bus_strobe_pair[0]));
      @(negedge hclk);
      cmp("mirrored strobe", 32'h1, 32'(bus_strobe_pair[0]));
      cmp("bus d strobe", 32'h0, 32'(bus_strobe_pair[3]));
    end
    pat = 2'h2;
    wr(framer_pkg::OFS_PATSEL, 32'h2);
    for (int i = 0; i < 2; i++) begin
      ctrl = 7'h43;
      single_ended_sync_pin <= i[0];
      wr(framer_pkg::OFS_CTRL, 32'h43);
      repeat (20) @(posedge hclk);
    end
    foreach (d[i]) begin
      ena = i == 0 ? 8'h33 : 8'hff;
      wr(framer_pkg::OFS_CLKSTR, 32'(ena));
      repeat (20) @(posedge hclk);
    end
    for (int i = 0; i < 4; i++) begin
      flen = i == 0 ? 8'h01 : i == 1 ? 8'h03 : i == 2 ? 8'h00 : 8'h05;
      wr(framer_pkg::OFS_FRAME, 32'(flen));
      repeat (780) @(posedge hclk);
    end
    chk = 1'b0;
    foreach (d[i]) begin
      repeat ($urandom_range(11, 3)) @(posedge hclk);
      sysref_in <= 1'b1;
      d[i] = 0;
      do begin
        @(negedge hclk);
        d[i]++;
      end while (!(d[i] > 4 && bus_strobe_pair[0] === 1'b1) && d[i] < 300);
      @(posedge hclk);
      sysref_in <= 1'b0;
    end
    cmp("sysref to strobe", d[0], d[1]);
    cmp("sysref latency", 32'(4 + flen), d[0]);
    tally_and_finish();
  end
endmodule
`default_nettype wire
